// *** rtl/uart_pkg.sv ***
package uart_pkg;
	localparam logic [7:0] MODE_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam logic [7:0] BAUD_ADDR = 8'h08;
	localparam logic [7:0] TXD_ADDR  = 8'h0C;
	localparam logic [7:0] RXD_ADDR  = 8'h10;
	localparam logic [7:0] FLAG_ADDR = 8'h14;
	localparam logic [7:0] OSC_ADDR  = 8'h18;
	localparam int TXE_BIT    = 7;
	localparam int RXE_BIT    = 6;
	localparam int PAR_HI     = 5;
	localparam int PAR_LO     = 4;
	localparam int CHAR8_BIT  = 3;
	localparam int STOP2_BIT  = 2;
	localparam int EXTCLK_BIT = 0;
	localparam int PE_BIT     = 2;
	localparam int FE_BIT     = 1;
	localparam int OE_BIT     = 0;
	localparam int TXC_BIT    = 0;
	localparam int RXF_BIT    = 1;
	localparam int HALVE_BIT  = 0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] OSC_RST  = 8'h00;
	localparam logic [4:0] BASE_COUNT = 5'h10;
	localparam logic [3:0] TPS_SLOW   = 4'h0;
	localparam logic [3:0] N_SLOW     = 4'hB;
	localparam logic [3:0] TPS_FIRST  = 4'h5;
	localparam logic [3:0] TPS_LAST   = 4'hE;
	localparam logic [3:0] TPS_OFFSET = 4'h4;
	localparam logic [2:0] BITS7 = 3'h6;
	localparam logic [2:0] BITS8 = 3'h7;
	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ZERO = 2'h1,
		PAR_ODD  = 2'h2,
		PAR_EVEN = 2'h3
	} parity_e;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_START = 3'b001,
		S_DATA  = 3'b011,
		S_PAR   = 3'b010,
		S_STOP  = 3'b110
	} frame_e;
endpackage

// *** rtl/half_bit_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module half_bit_timer (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       restart_i,
	input  wire logic       tick_i,
	input  wire logic [3:0] k_i,
	output logic            half_o
);
	import uart_pkg::*;
	logic [4:0] count_q;
	logic [4:0] last;
	assign last = BASE_COUNT + {1'b0, k_i} - 5'h01;
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			count_q <= 5'h00;
			half_o  <= 1'b0;
		end else if (tick_i && count_q == last) begin
			count_q <= 5'h00;
			half_o  <= 1'b1;
		end else begin
			if (tick_i) begin
				count_q <= count_q + 5'h01;
			end
			half_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** rtl/async_serial_uart.sv ***
// Operation
// - External pin clock: bit rate is pin frequency over two times (16 plus k).
// - Frame: start, 7 or 8 data, optional parity, one or two stops.
// - Seven-bit mode ignores transmit bit 7 and returns received bit 7 zero.
// - Even parity: transmit makes total ones even; odd total received is error.
// - Odd parity: transmit makes total ones odd; even total received is error.
// - Zero parity sends zero and never checks the received parity bit.
// - No parity: no parity bit sent, none expected, no parity error.
// - Writing transmit data starts a frame with start, parity, stops added.
// - When the shifter empties, raise transmit-complete request and set its flag.
// - Receiving happens only while receive enable is set, on the baud clock.
// - Low line starts counter; low again at half bit confirms start, realigns.
// - Receiver finishes after one stop bit even with two configured.
// - Frame end moves data to buffer and requests, also on errors.
// - Clearing receive enable mid-frame aborts without buffer, status or requests.
// - Errors set status flags and request error before the completion request.
// - Parity mismatch, missing stop bit, and unread buffer overrun are errors.
// - Buffer read or next completion clears status; new errors set again.
// - Late receive disable keeps, updates, or updates and requests by progress; this design discards the frame at any point before the stop sample.
// - Main clock: bit rate is clock over two to n times (16 plus k) with oscillator bit 0 set, two to n plus one times when it is clear.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module async_serial_uart (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        rxd_i,
	input  wire logic        ext_baud_clock_pin_i,
	output logic             txd_o,
	output logic             tx_complete_request_o,
	output logic             rx_complete_request_o,
	output logic             rx_error_request_o
);
	import uart_pkg::*;

	logic [7:0] async_mode_reg_q;
	logic [7:0] baud_gen_control_q;
	logic [7:0] oscillator_mode_reg_q;
	logic [2:0] async_error_status_q;
	logic [7:0] rx_buffer_q;
	logic       tx_complete_flag_q;
	logic       rx_full_q;
	logic       req_take;
	logic       wr;
	logic       rd_rxbuf;
	logic       clr_txflag;
	parity_e    parity;
	logic [2:0] last_bit;
	logic [3:0] baud_divisor_k;

	assign req_take   = cyc_i && stb_i && !ack_o;
	assign wr         = req_take && we_i && sel_i[0];
	assign rd_rxbuf   = req_take && !we_i && adr_i == RXD_ADDR;
	assign clr_txflag = wr && adr_i == FLAG_ADDR && dat_i[TXC_BIT];
	assign parity     = parity_e'(async_mode_reg_q[PAR_HI:PAR_LO]);
	assign last_bit   = async_mode_reg_q[CHAR8_BIT] ? BITS8 : BITS7;
	assign baud_divisor_k = baud_gen_control_q[3:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			async_mode_reg_q      <= MODE_RST;
			baud_gen_control_q    <= BAUD_RST;
			oscillator_mode_reg_q <= OSC_RST;
		end else if (wr) begin
			if (adr_i == MODE_ADDR) begin
				async_mode_reg_q <= dat_i[7:0];
			end else if (adr_i == BAUD_ADDR) begin
				baud_gen_control_q <= dat_i[7:0];
			end else if (adr_i == OSC_ADDR) begin
				oscillator_mode_reg_q <= dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req_take;
			dat_o <= 32'h0000_0000;
			if (req_take && !we_i) begin
				if (adr_i == MODE_ADDR) begin
					dat_o[7:0] <= async_mode_reg_q;
				end else if (adr_i == STAT_ADDR) begin
					dat_o[2:0] <= async_error_status_q;
				end else if (adr_i == BAUD_ADDR) begin
					dat_o[7:0] <= baud_gen_control_q;
				end else if (adr_i == RXD_ADDR) begin
					dat_o[7:0] <= rx_buffer_q;
				end else if (adr_i == FLAG_ADDR) begin
					dat_o[TXC_BIT] <= tx_complete_flag_q;
					dat_o[RXF_BIT] <= rx_full_q;
				end else if (adr_i == OSC_ADDR) begin
					dat_o[7:0] <= oscillator_mode_reg_q;
				end
			end
		end
	end

	// Baud source: pin edges, or main clock through the prescaler.
	logic        ext_q;
	logic        fxx_q;
	logic [10:0] pre_q;
	logic [3:0]  tps;
	logic [3:0]  n;
	logic [10:0] pre_last;
	logic        fxx_en;
	logic        src_tick;
	assign tps    = baud_gen_control_q[7:4];
	assign fxx_en = oscillator_mode_reg_q[HALVE_BIT] || fxx_q;
	always_comb begin
		if (tps == TPS_SLOW) begin
			n = N_SLOW;
		end else if (tps >= TPS_FIRST && tps <= TPS_LAST) begin
			n = tps - TPS_OFFSET;
		end else begin
			n = 4'h1;
		end
	end
	assign pre_last = (11'h001 << (n - 4'h1)) - 11'h001;
	assign src_tick = async_mode_reg_q[EXTCLK_BIT] ? (ext_baud_clock_pin_i && !ext_q)
	                                               : (fxx_en && pre_q == pre_last);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_q <= 1'b0;
			fxx_q <= 1'b0;
			pre_q <= 11'h000;
		end else begin
			ext_q <= ext_baud_clock_pin_i;
			fxx_q <= !fxx_q;
			if (fxx_en) begin
				pre_q <= (pre_q >= pre_last) ? 11'h000 : pre_q + 11'h001;
			end
		end
	end

	// Transmitter.
	frame_e     tx_state_q;
	logic [7:0] tx_shift_reg_q;
	logic [2:0] tx_bit_q;
	logic       tx_phase_q;
	logic       tx_par_q;
	logic       tx_restart;
	logic       tx_half;
	logic       tx_bit_end;
	logic       tx_load;
	logic       tx_done;
	assign tx_load    = wr && adr_i == TXD_ADDR && tx_state_q == S_IDLE
	                    && async_mode_reg_q[TXE_BIT];
	assign tx_restart = tx_load;
	assign tx_bit_end = tx_half && tx_phase_q;
	assign tx_done    = tx_bit_end && tx_state_q == S_STOP && async_mode_reg_q[TXE_BIT]
	                    && (tx_bit_q[0] || !async_mode_reg_q[STOP2_BIT]);

	half_bit_timer tx_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (tx_restart),
		.tick_i    (src_tick),
		.k_i       (baud_divisor_k),
		.half_o    (tx_half)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i || !async_mode_reg_q[TXE_BIT]) begin
			tx_state_q     <= S_IDLE;
			tx_shift_reg_q <= 8'hFF;
			tx_bit_q       <= 3'h0;
			tx_phase_q     <= 1'b0;
			tx_par_q       <= 1'b0;
			txd_o          <= 1'b1;
		end else if (tx_load) begin
			tx_state_q <= S_START;
			// drop bit 7 in seven-bit mode.
			tx_shift_reg_q <= async_mode_reg_q[CHAR8_BIT] ? dat_i[7:0] : {1'b0, dat_i[6:0]};
			tx_bit_q   <= 3'h0;
			tx_phase_q <= 1'b0;
			txd_o      <= 1'b0;
			if (parity == PAR_EVEN) begin
				tx_par_q <= ^dat_i[6:0] ^ (async_mode_reg_q[CHAR8_BIT] & dat_i[7]);
			end else if (parity == PAR_ODD) begin
				tx_par_q <= ~(^dat_i[6:0] ^ (async_mode_reg_q[CHAR8_BIT] & dat_i[7]));
			end else begin
				tx_par_q <= 1'b0;
			end
		end else if (tx_half) begin
			tx_phase_q <= !tx_phase_q;
			if (tx_phase_q) begin
				case (tx_state_q)
					S_START: begin
						tx_state_q     <= S_DATA;
						txd_o          <= tx_shift_reg_q[0];
						tx_shift_reg_q <= {1'b1, tx_shift_reg_q[7:1]};
					end
					S_DATA: begin
						if (tx_bit_q == last_bit) begin
							tx_bit_q <= 3'h0;
							if (parity == PAR_NONE) begin
								tx_state_q <= S_STOP;
								txd_o      <= 1'b1;
							end else begin
								tx_state_q <= S_PAR;
								txd_o      <= tx_par_q;
							end
						end else begin
							tx_bit_q       <= tx_bit_q + 3'h1;
							txd_o          <= tx_shift_reg_q[0];
							tx_shift_reg_q <= {1'b1, tx_shift_reg_q[7:1]};
						end
					end
					S_PAR: begin
						tx_state_q <= S_STOP;
						txd_o      <= 1'b1;
					end
					S_STOP: begin
						tx_bit_q <= tx_bit_q + 3'h1;
						if (tx_done) begin
							tx_state_q <= S_IDLE;
						end
					end
					default: begin
						tx_state_q <= S_IDLE;
						txd_o      <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_complete_request_o <= 1'b0;
			tx_complete_flag_q    <= 1'b0;
		end else begin
			tx_complete_request_o <= tx_done;
			if (tx_done) begin
				tx_complete_flag_q <= 1'b1;
			end else if (clr_txflag) begin
				tx_complete_flag_q <= 1'b0;
			end
		end
	end

	// Receiver.
	frame_e     rx_state_q;
	logic [7:0] rx_shift_q;
	logic [2:0] rx_bit_q;
	logic       rx_phase_q;
	logic       rx_ones_q;
	logic       rx_half;
	logic       rx_restart;
	logic       rx_sample;
	logic       rx_en;
	logic       rx_done;
	logic [2:0] rx_err;
	logic       rx_pe;
	assign rx_en      = async_mode_reg_q[RXE_BIT];
	assign rx_restart = rx_en && ((rx_state_q == S_IDLE && !rxd_i)
	                    || (rx_state_q == S_START && rx_half && !rxd_i));
	assign rx_sample  = rx_half && rx_phase_q;
	// one stop bit ends the frame.
	assign rx_done    = rx_en && rx_sample && rx_state_q == S_STOP;
	assign rx_pe      = (parity == PAR_EVEN && rx_ones_q) || (parity == PAR_ODD && !rx_ones_q);
	assign rx_err[PE_BIT] = rx_pe;
	assign rx_err[FE_BIT] = !rxd_i;
	assign rx_err[OE_BIT] = rx_full_q && !rd_rxbuf;

	half_bit_timer rx_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (rx_restart),
		.tick_i    (src_tick),
		.k_i       (baud_divisor_k),
		.half_o    (rx_half)
	);

	// receive only while enabled; abort at once.
	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_en) begin
			rx_state_q <= S_IDLE;
			rx_shift_q <= 8'h00;
			rx_bit_q   <= 3'h0;
			rx_phase_q <= 1'b0;
			rx_ones_q  <= 1'b0;
		end else if (rx_restart) begin
			rx_state_q <= (rx_state_q == S_IDLE) ? S_START : S_DATA;
			rx_phase_q <= 1'b0;
			rx_bit_q   <= 3'h0;
			rx_ones_q  <= 1'b0;
			rx_shift_q <= 8'h00;
		end else if (rx_state_q == S_START && rx_half) begin
			rx_state_q <= S_IDLE;
		end else if (rx_half) begin
			rx_phase_q <= !rx_phase_q;
			if (rx_phase_q) begin
				case (rx_state_q)
					S_DATA: begin
						rx_ones_q <= rx_ones_q ^ rxd_i;
						rx_shift_q[rx_bit_q] <= rxd_i;
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == last_bit) begin
							rx_state_q <= (parity == PAR_NONE) ? S_STOP : S_PAR;
						end
					end
					S_PAR: begin
						rx_ones_q  <= rx_ones_q ^ rxd_i;
						rx_state_q <= S_STOP;
					end
					default: begin
						rx_state_q <= S_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buffer_q          <= 8'h00;
			rx_full_q            <= 1'b0;
			async_error_status_q <= 3'h0;
		end else if (rx_done) begin
			rx_buffer_q          <= rx_shift_q;
			rx_full_q            <= 1'b1;
			async_error_status_q <= rx_err;
		end else if (rd_rxbuf) begin
			rx_full_q            <= 1'b0;
			async_error_status_q <= 3'h0;
		end
	end

	// error request one cycle ahead of completion.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_error_request_o    <= 1'b0;
			rx_complete_request_o <= 1'b0;
		end else begin
			rx_error_request_o    <= rx_done && (rx_err != 3'h0);
			rx_complete_request_o <= rx_error_request_o || (rx_done && rx_err == 3'h0);
		end
	end
endmodule
`default_nettype wire

// *** sim/uart_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_checker (
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	txd_o,
	input wire logic	tx_complete_request_o,
	input wire logic	rx_complete_request_o,
	input wire logic	rx_error_request_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_err_then_done: assert property (rx_error_request_o |=> rx_complete_request_o)
		else $error("no completion after error");
	a_done_not_err: assert property (rx_complete_request_o |-> !rx_error_request_o)
		else $error("error and completion together");
	a_err_pulse: assert property (rx_error_request_o |=> !rx_error_request_o [*8])
		else $error("error request repeated");
	a_done_gap: assert property (rx_complete_request_o |=> !rx_complete_request_o [*8])
		else $error("completion repeated");
	a_txc_stop: assert property (tx_complete_request_o |-> txd_o && $past(txd_o, 16))
		else $error("completion without stop level");
	a_txc_pulse: assert property (tx_complete_request_o |=> !tx_complete_request_o)
		else $error("completion longer than a cycle");
	a_start_held: assert property ($fell(txd_o) |-> !txd_o [*8])
		else $error("start bit too short");
	a_idle_before: assert property ($fell(txd_o) |-> $past(txd_o, 8))
		else $error("start bit without idle line");
	c_rx_err: cover property (rx_error_request_o);
	c_rx_done: cover property (rx_complete_request_o);
	c_tx_done: cover property (tx_complete_request_o);
endmodule
`default_nettype wire

// *** sim/serial_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
	input  wire logic	clk_i,
	input  wire logic	txd_i,
	output logic		rxd_o
);
	initial rxd_o = 1'h1;
	task automatic send(input logic [11:0] bits, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (bt) @(posedge clk_i);
		end
		rxd_o <= 1'h1;
		@(posedge clk_i);
	endtask
	task automatic grab(output logic [11:0] bits, input int n, input int bt);
		bits = 12'hFFF;
		@(negedge txd_i);
		repeat (bt / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd_i;
			repeat (bt) @(posedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// *** sim/tb_async_serial_uart.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_uart;
	import uart_pkg::*;
	logic		clk, rst, cyc, stb, we, ack, rxd, ext, txd, txc, rxc, receive_enable_bit;
	logic		c8, s2, x, pe, fe;
	logic [1:0]	p;
	logic [3:0]	sel, k;
	logic [7:0]	adr, d, m;
	logic [11:0]	f, fr, g;
	logic [31:0]	wdat, rdat, rv, r, seed;
	int		mismatches, checked, done_cnt, err_cnt, bt, nb, nt, nr, e, c0, e0, tx_cnt, t0;
	async_serial_uart async_serial_uart_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .rxd_i(rxd), .ext_baud_clock_pin_i(ext), .txd_o(txd),
		.tx_complete_request_o(txc), .rx_complete_request_o(rxc),
		.rx_error_request_o(receive_enable_bit));
	serial_far_end far_i (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		ext <= ~ext;
		done_cnt <= done_cnt + int'(rxc);
		err_cnt <= err_cnt + int'(receive_enable_bit);
		tx_cnt <= tx_cnt + int'(txc);
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [11:0] fbits(logic [7:0] v, logic b8, logic [1:0] pm);
		logic [11:0] o;
		int n;
		n = b8 ? 8 : 7;
		o = 12'hFFE;
		for (int i = 0; i < n; i++) o[i + 1] = v[i];
		v = b8 ? v : {1'h0, v[6:0]};
		if (pm != 2'h0) o[n + 1] = (pm == 2'h3) ? ^v : (pm == 2'h2) ? ~^v : 1'h0;
		return o;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dv);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h00_0000, dv};
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		rv = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		final_report();
	end
	initial begin
		seed = 32'h0000_0014;
		{rst, cyc, stb, we, ext} = 5'h10;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0000_0000;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		wb(1'h1, OSC_ADDR, 8'h01);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			d = r[7:0];
			p = 2'(i);
			{x, s2, c8} = r[10:8];
			k = 4'(r[15:12] % 15);
			e = int'(r[17:16]) % 3;
			bt = ((x || r[18]) ? 4 : 2) * (16 + int'(k));
			nb = c8 ? 8 : 7;
			nr = 2 + nb + int'(p != 2'h0);
			nt = nr + int'(s2);
			m = {2'h3, p, c8, s2, 1'h0, x};
			wb(1'h1, MODE_ADDR, m);
			wb(1'h1, BAUD_ADDR, {4'h5 + 4'(r[18]), k});
			f = fbits(d, c8, p);
			t0 = tx_cnt;
			fork
				far_i.grab(g, nt, bt);
				wb(1'h1, TXD_ADDR, d);
			join
			check(32'(g), 32'(f));
			repeat (bt) @(posedge clk);
			check(tx_cnt - t0, 1);
			wb(1'h0, FLAG_ADDR, 8'h00);
			check(rv, 1);
			wb(1'h1, FLAG_ADDR, 8'h01);
			fr = f;
			if (e == 1 && p != 2'h0) fr[nb + 1] = ~fr[nb + 1];
			if (e == 2) fr[nr - 1] = 1'h0;
			pe = e == 1 && p[1];
			fe = e == 2;
			c0 = done_cnt;
			e0 = err_cnt;
			far_i.send(fr, nr, bt);
			repeat (4) @(posedge clk);
			check(done_cnt - c0, 1);
			check(err_cnt - e0, int'(pe | fe));
			wb(1'h0, STAT_ADDR, 8'h00);
			check(rv, {pe, fe, 1'h0});
			wb(1'h0, RXD_ADDR, 8'h00);
			check(rv, {c8 & d[7], d[6:0]});
			wb(1'h0, STAT_ADDR, 8'h00);
			check(rv, 0);
			$display("test %0d done", i);
		end
		c0 = done_cnt;
		far_i.send(f, nr, bt);
		far_i.send(f, nr, bt);
		repeat (4) @(posedge clk);
		wb(1'h0, STAT_ADDR, 8'h00);
		check(rv, 1);
		wb(1'h0, RXD_ADDR, 8'h00);
		check(rv, {c8 & d[7], d[6:0]});
		$display("overrun test done");
		fork
			far_i.send(f, nr, bt);
			begin
				repeat (3 * bt) @(posedge clk);
				wb(1'h1, MODE_ADDR, m & 8'hBF);
			end
		join
		repeat (bt) @(posedge clk);
		check(done_cnt - c0, 2);
		wb(1'h0, STAT_ADDR, 8'h00);
		check(rv, 0);
		wb(1'h0, FLAG_ADDR, 8'h00);
		check(rv, 0);
		$display("abort test done");
		t0 = tx_cnt;
		wb(1'h1, TXD_ADDR, d);
		repeat (bt * 2 + bt / 2) @(posedge clk);
		wb(1'h1, MODE_ADDR, m & 8'h3F);
		check(txd, 1);
		// all ones written while disabled, so nothing is loaded.
		wb(1'h1, TXD_ADDR, 8'hFF);
		wb(1'h1, MODE_ADDR, m & 8'hBF);
		check(tx_cnt - t0, 0);
		fork
			far_i.grab(g, nt, bt);
			wb(1'h1, TXD_ADDR, d);
		join
		check(32'(g), 32'(f));
		repeat (bt) @(posedge clk);
		check(tx_cnt - t0, 1);
		$display("tx abort test done");
		final_report();
	end
endmodule
bind async_serial_uart uart_checker uart_checker_i (.clk_i(clk_i), .rst_i(rst_i),
	.txd_o(txd_o), .tx_complete_request_o(tx_complete_request_o),
	.rx_complete_request_o(rx_complete_request_o), .rx_error_request_o(rx_error_request_o));
`default_nettype wire
